// ==== rasc_pkg.sv ====
package rasc_pkg;

    // register byte offsets on the control bus
    localparam logic [7:0] RASC_OFF_PTR = 8'h00;
    localparam logic [7:0] RASC_OFF_TOP_LOW = 8'h04;
    localparam logic [7:0] RASC_OFF_TOP_HIGH = 8'h08;
    localparam logic [7:0] RASC_OFF_TOP_UPPER = 8'h0c;
    localparam logic [7:0] RASC_OFF_CTRL = 8'h10;

    // pointer and status register layout
    localparam int RASC_FULL_BIT = 7;
    localparam int RASC_UNF_BIT = 6;
    localparam int RASC_PTR_W = 5;
    localparam int RASC_PC_W = 21;
    localparam int RASC_UPPER_W = 5;
    localparam logic [4:0] RASC_PTR_RST = 5'h00;
    localparam logic [4:0] RASC_PTR_MAX = 5'h1f;
    localparam logic [4:0] RASC_PTR_LAST = 5'h1e;

    // control register layout
    localparam int RASC_CTRL_EN_BIT = 0;
    localparam logic RASC_CTRL_EN_RST = 1'b1;

    // return address adjustment on an overflow that resets
    localparam logic [20:0] RASC_PC_STEP = 21'h000002;
    localparam logic [20:0] RASC_PC_ZERO = 21'h000000;

    // bus responses
    localparam logic [1:0] RASC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RASC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        RASC_OP_NONE,
        RASC_OP_PUSH,
        RASC_OP_POP,
        RASC_OP_SW_PUSH,
        RASC_OP_SW_POP
    } rasc_op_type;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working_register;
        logic [3:0] bank_select_register;
    } rasc_ctx_type;

    typedef struct packed {
        rasc_op_type op;
        logic fast;
        logic irq;
        logic [20:0] pc;
    } rasc_req_type;

    typedef struct packed {
        logic pc_valid;
        logic [20:0] pc_value;
        logic restore_valid;
        rasc_ctx_type ctx;
    } rasc_ans_type;

endpackage

// ==== rasc_top.sv ====
`timescale 1ns/1ps

module rasc_top
    import rasc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // instruction sequencer
    input wire rasc_req_type seq_req,
    input wire rasc_ctx_type ctx_now,
    output rasc_ans_type seq_ans,
    // reset logic
    output logic stack_reset_req
);

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == RASC_OFF_PTR) || (a == RASC_OFF_TOP_LOW) ||
            (a == RASC_OFF_TOP_HIGH) || (a == RASC_OFF_TOP_UPPER) ||
            (a == RASC_OFF_CTRL);
    endfunction

    // byte lane of a top entry register, 3 when not one
    function automatic logic [1:0] top_lane(input logic [7:0] a);
        if (a == RASC_OFF_TOP_LOW) begin
            top_lane = 2'h0;
        end else if (a == RASC_OFF_TOP_HIGH) begin
            top_lane = 2'h1;
        end else if (a == RASC_OFF_TOP_UPPER) begin
            top_lane = 2'h2;
        end else begin
            top_lane = 2'h3;
        end
    endfunction

    // stack storage; index zero deliberately absent
    logic [RASC_PC_W-1:0] stack_mem [1:31];

    logic [4:0] pointer_value_bits_reg;
    logic stack_full_flag_reg;
    logic stack_underflow_flag_reg;
    logic stack_error_reset_enable_reg;
    rasc_ctx_type shadow_reg;

    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [7:0] w_data_reg;
    logic w_strb0_reg;
    logic w_held_reg;
    logic [1:0] bresp_reg;
    logic bvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;

    logic stack_reset_req_reg;
    rasc_ans_type ans_reg;

    logic wr_fire;
    logic wr_ptr;
    logic wr_ctrl;
    logic [1:0] wr_lane;
    logic do_push;
    logic do_pop;
    logic empty;
    logic at_top;
    logic at_last;
    logic full_set;
    logic unf_set;
    logic [4:0] push_index;
    logic [4:0] pointer_value_bits_next;
    logic [RASC_PC_W-1:0] push_value;
    logic [RASC_PC_W-1:0] top_value;

    // bus handshakes and output drives
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign seq_ans = ans_reg;
    assign stack_reset_req = stack_reset_req_reg;

    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_ptr = wr_fire && w_strb0_reg && (aw_addr_reg == RASC_OFF_PTR);
    assign wr_ctrl = wr_fire && w_strb0_reg &&
        (aw_addr_reg == RASC_OFF_CTRL);
    assign wr_lane = (wr_fire && w_strb0_reg) ? top_lane(aw_addr_reg) :
        2'h3;

    assign do_push = (seq_req.op == RASC_OP_PUSH) ||
        (seq_req.op == RASC_OP_SW_PUSH);
    assign do_pop = (seq_req.op == RASC_OP_POP) ||
        (seq_req.op == RASC_OP_SW_POP);
    assign empty = (pointer_value_bits_reg == RASC_PTR_RST);
    assign at_top = (pointer_value_bits_reg == RASC_PTR_MAX);
    assign at_last = (pointer_value_bits_reg == RASC_PTR_LAST);
    assign push_index = pointer_value_bits_reg + 5'h01;
    assign full_set = do_push && (at_last || at_top);
    assign unf_set = do_pop && empty;
    assign top_value = empty ? RASC_PC_ZERO :
        stack_mem[pointer_value_bits_reg];

    // an overflow that will reset returns past the call
    assign push_value = (at_last && stack_error_reset_enable_reg) ?
        seq_req.pc + RASC_PC_STEP : seq_req.pc;

    // a sequencer push or pop that moves the pointer wins over a same-cycle software write
    always_comb begin
        pointer_value_bits_next = pointer_value_bits_reg;
        if (do_push && !at_top) begin
            pointer_value_bits_next = push_index;
        end else if (do_pop && !empty) begin
            pointer_value_bits_next =
                pointer_value_bits_reg - 5'h01;
        end else if (wr_ptr) begin
            pointer_value_bits_next = w_data_reg[4:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pointer_value_bits_reg <= RASC_PTR_RST;
        end else begin
            pointer_value_bits_reg <= pointer_value_bits_next;
        end
    end

    // storage has no reset; entries above the pointer are dead
    always_ff @(posedge clk) begin
        if (do_push && !at_top) begin
            stack_mem[push_index] <= push_value;
        end else if (wr_lane != 2'h3 && !empty) begin
            case (wr_lane)
                2'h0: begin
                    stack_mem[pointer_value_bits_reg][7:0] <=
                        w_data_reg;
                end
                2'h1: begin
                    stack_mem[pointer_value_bits_reg][15:8] <=
                        w_data_reg;
                end
                default: begin
                    stack_mem[pointer_value_bits_reg][20:16] <=
                        w_data_reg[RASC_UPPER_W-1:0];
                end
            endcase
        end
    end

    // flags survive stack resets; power-on or a pointer write with the bit at zero clears them
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            stack_full_flag_reg <= 1'b0;
        end else if (full_set) begin
            stack_full_flag_reg <= 1'b1;
        end else if (wr_ptr && !w_data_reg[RASC_FULL_BIT]) begin
            stack_full_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            stack_underflow_flag_reg <= 1'b0;
        end else if (unf_set) begin
            stack_underflow_flag_reg <= 1'b1;
        end else if (wr_ptr && !w_data_reg[RASC_UNF_BIT]) begin
            stack_underflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_error_reset_enable_reg <= RASC_CTRL_EN_RST;
        end else if (wr_ctrl) begin
            stack_error_reset_enable_reg <= w_data_reg[RASC_CTRL_EN_BIT];
        end
    end

    // a request is one pulse; the reset logic stretches it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_reset_req_reg <= 1'b0;
        end else begin
            stack_reset_req_reg <= stack_error_reset_enable_reg &&
                (full_set || unf_set);
        end
    end

    // one level only, so a later save simply overwrites
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_reg <= '0;
        end else if (seq_req.op == RASC_OP_PUSH &&
            (seq_req.irq || seq_req.fast)) begin
            shadow_reg <= ctx_now;
        end
    end

    // answers to the sequencer, one cycle after the request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ans_reg <= '0;
        end else begin
            ans_reg.pc_valid <= (seq_req.op == RASC_OP_POP);
            ans_reg.pc_value <= top_value;
            ans_reg.restore_valid <= (seq_req.op == RASC_OP_POP) &&
                seq_req.fast;
            ans_reg.ctx <= shadow_reg;
        end
    end

    // write address and data are taken in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RASC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(aw_addr_reg) ? RASC_RESP_OKAY :
                RASC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read data shows live state at the address edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RASC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= is_mapped({s_axi_araddr[7:2], 2'h0}) ?
                RASC_RESP_OKAY : RASC_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'h0})
                RASC_OFF_PTR: begin
                    rdata_reg <= {24'h000000, stack_full_flag_reg,
                        stack_underflow_flag_reg, 1'b0,
                        pointer_value_bits_reg};
                end
                RASC_OFF_TOP_LOW: begin
                    rdata_reg <= {24'h000000, top_value[7:0]};
                end
                RASC_OFF_TOP_HIGH: begin
                    rdata_reg <= {24'h000000, top_value[15:8]};
                end
                RASC_OFF_TOP_UPPER: begin
                    rdata_reg <= {27'h0000000, top_value[20:16]};
                end
                RASC_OFF_CTRL: begin
                    rdata_reg <= {31'h00000000,
                        stack_error_reset_enable_reg};
                end
                default: begin
                    rdata_reg <= 32'h00000000;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule

// ==== rasc_assertions.sv ====
`timescale 1ns/1ps
module rasc_chk
    import rasc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sequencer side
    input wire rasc_req_type seq_req,
    input wire rasc_ans_type seq_ans,
    input wire logic stack_reset_req,
    // bus answers
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_pop_answers: assert property (
        seq_req.op == RASC_OP_POP |=> seq_ans.pc_valid)
        else $error("pop gave no answer");
    a_no_stray_answer: assert property (
        seq_req.op != RASC_OP_POP |=> !seq_ans.pc_valid)
        else $error("answer without pop");
    a_fast_restore: assert property (
        seq_req.op == RASC_OP_POP && seq_req.fast |=> seq_ans.restore_valid)
        else $error("fast return did not restore");
    a_plain_keeps: assert property (
        seq_req.op == RASC_OP_POP && !seq_req.fast |=> !seq_ans.restore_valid)
        else $error("plain return restored");
    a_reset_cause: assert property (
        stack_reset_req |-> $past(seq_req.op) != RASC_OP_NONE)
        else $error("reset request without stack operation");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_read_turn: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
endmodule

bind rasc_top rasc_chk i_rasc_chk(.clk, .rst, .seq_req, .seq_ans,
    .stack_reset_req, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// ==== rasc_seq_model.sv ====
`timescale 1ns/1ps
module rasc_seq_model
    import rasc_pkg::*;
(
    // clock
    input wire logic clk,
    // requests to the stack
    output rasc_req_type seq_req,
    output rasc_ctx_type ctx_now
);
    initial begin
        seq_req = '0;
        ctx_now = '0;
    end
    // held one edge; the caller idles or sends the next at once
    task automatic issue(input rasc_op_type op, input logic f,
        input logic i, input logic [20:0] pc, input rasc_ctx_type c);
        seq_req <= '{op, f, i, pc};
        ctx_now <= c;
        @(posedge clk);
    endtask
    // live context keeps moving so a stale capture shows
    task automatic idle();
        seq_req.op <= RASC_OP_NONE;
        ctx_now <= rasc_ctx_type'(20'($urandom));
        @(posedge clk);
    endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import rasc_pkg::*;
    localparam logic [63:0] RQ = 64'hffff_0000_0000_0000;
    logic clk, rst, por, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, stack_reset_req, en;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, fl;
    rasc_req_type seq_req;
    rasc_ctx_type ctx_now, shadow;
    rasc_ans_type seq_ans;
    logic [63:0] q[$];
    logic [20:0] mem[32];
    logic [4:0] ptr;
    int failures, compares, cyc;
    rasc_top i_rasc_top(.clk, .rst, .por, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .seq_req, .ctx_now, .seq_ans,
        .stack_reset_req);
    rasc_seq_model i_rasc_seq_model(.clk, .seq_req, .ctx_now);
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        if (q.size() != 0) failures++;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] v);
        compares++;
        if (q.size() == 0 || q[0] !== v) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time,
                (q.size() != 0) ? q[0] : 64'h0, v);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            finish_test();
        end
        if (!rst && s_axi_rvalid && s_axi_rready)
            cmp({30'h0, s_axi_rresp, s_axi_rdata});
        if (!rst && s_axi_bvalid && s_axi_bready)
            cmp({62'h0, s_axi_bresp});
        if (!rst && seq_ans.pc_valid)
            cmp({22'h0, seq_ans.restore_valid,
                seq_ans.restore_valid ? seq_ans.ctx : 20'h0,
                seq_ans.pc_value});
        if (!rst && stack_reset_req) cmp(RQ);
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] r = RASC_RESP_OKAY);
        logic aw, w;
        aw = 0;
        w = 0;
        q.push_back({62'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($urandom), d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end
        repeat ($urandom_range(2)) @(posedge clk);
        s_axi_bready <= 1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic [1:0] r = RASC_RESP_OKAY);
        q.push_back({30'h0, r, 24'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        repeat ($urandom_range(2)) @(posedge clk);
        s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    task automatic rp();
        rd(RASC_OFF_PTR, {fl, 1'b0, ptr});
    endtask
    task automatic wp(input logic [7:0] d);
        wr(RASC_OFF_PTR, d);
        ptr = d[4:0];
        fl = fl & d[7:6];
    endtask
    task automatic rtop(input logic [20:0] e);
        rd(RASC_OFF_TOP_LOW, e[7:0]);
        rd(RASC_OFF_TOP_HIGH, e[15:8]);
        rd(RASC_OFF_TOP_UPPER, {3'h0, e[20:16]});
    endtask
    // expected stack behaviour kept alongside each request
    task automatic sq(input rasc_op_type op, input logic f, input logic i,
        input logic b = 0);
        logic [20:0] pc;
        rasc_ctx_type c;
        pc = 21'($urandom);
        c = rasc_ctx_type'(20'($urandom));
        if (op == RASC_OP_PUSH && (f || i)) shadow = c;
        if (op == RASC_OP_PUSH || op == RASC_OP_SW_PUSH) begin
            if (ptr >= RASC_PTR_LAST) fl[1] = 1;
            if (ptr >= RASC_PTR_LAST && en) q.push_back(RQ);
            if (ptr != RASC_PTR_MAX) begin
                ptr++;
                mem[ptr] = (ptr == RASC_PTR_MAX && en) ?
                    pc + RASC_PC_STEP : pc;
            end
        end
        if (op == RASC_OP_POP) begin
            q.push_back({22'h0, f, f ? shadow : 20'h0,
                (ptr != 0) ? mem[ptr] : RASC_PC_ZERO});
            if (ptr == 0 && en) q.push_back(RQ);
            if (ptr == 0) fl[0] = 1;
            else ptr--;
        end
        if (op == RASC_OP_SW_POP) ptr--;
        i_rasc_seq_model.issue(op, f, i, pc, c);
        if (!b) i_rasc_seq_model.idle();
    endtask
    initial begin
        void'($urandom(25247));
        {rst, por, en} = 3'h7;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, fl, ptr, shadow} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {failures, compares, cyc} = '0;
        repeat (16) @(posedge clk);
        rst <= 0;
        por <= 0;
        @(posedge clk);
        rp();
        rd(RASC_OFF_CTRL, 8'h01);
        rd(8'h14, 8'h00, RASC_RESP_SLVERR);
        wr(8'h14, 8'h5a, RASC_RESP_SLVERR);
        sq(RASC_OP_PUSH, 0, 1, 1);
        sq(RASC_OP_PUSH, 0, 1);
        rtop(mem[ptr]);
        sq(RASC_OP_POP, 1, 0);
        sq(RASC_OP_PUSH, 1, 0);
        sq(RASC_OP_POP, 0, 0);
        sq(RASC_OP_POP, 1, 0);
        sq(RASC_OP_SW_PUSH, 0, 0, 1);
        sq(RASC_OP_PUSH, 0, 0, 1);
        sq(RASC_OP_SW_POP, 0, 0);
        rtop(mem[ptr]);
        mem[ptr] = 21'($urandom);
        wr(RASC_OFF_TOP_LOW, mem[ptr][7:0]);
        wr(RASC_OFF_TOP_HIGH, mem[ptr][15:8]);
        wr(RASC_OFF_TOP_UPPER, {3'h0, mem[ptr][20:16]});
        sq(RASC_OP_POP, 0, 0);
        wr(RASC_OFF_CTRL, 8'h00);
        en = 0;
        for (int k = 0; k < 32; k++) sq(RASC_OP_PUSH, 0, 0, k < 31);
        rp();
        rtop(mem[31]);
        wp(8'h1e);
        wp(8'hde);
        rp();
        wp(8'h00);
        sq(RASC_OP_POP, 0, 0);
        rp();
        wr(RASC_OFF_CTRL, 8'h01);
        en = 1;
        wp(8'h1e);
        sq(RASC_OP_PUSH, 0, 0);
        rtop(mem[31]);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        @(posedge clk);
        {ptr, shadow} = '0;
        rp();
        {rst, por} <= 2'h3;
        @(posedge clk);
        {rst, por} <= 2'h0;
        @(posedge clk);
        fl = 0;
        rp();
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule
